// ---- design/frt_timer.sv ----
// 16-bit free-running timer with compare, capture and read buffer
//
// Contract
// - 16-bit counter free-runs, no clear on match
// - reset clears counter, then free-runs again
// - count equals compare raises interrupt request
// - compare accepts every 16-bit value
// - reset loads compare with all ones
// - capture latches count on selected trigger
// - edge field: off, rise, fall, both
// - clock field: full clock or divide-by-32
// - no capture while full clock selected
// - bit 7 shows output level, read-only
// - overflow sets bit 6; write 0 clears
// - bit 3 enables output inversion on match
// - bit 0 routes output to pin
// - reset clears mode control; byte writes
// - read buffer gives consistent 16-bit count
// - count undefined after stop release
// - direction bit 0 output, 1 input; reset FFH
// - match with inversion toggles pin, keeps counting
// - capture takes count within two count clocks
// - buffer freezes on low read, frees on high
`timescale 1ns/10ps
module frt_timer
  import frt_pkg::*;
(
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [15:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [7:0] RDATA_OUT,
  input wire logic CAPTURE_PIN_IN,
  output logic TIMER_PIN_OUT,
  output logic TIMER_PIN_OE_OUT,
  output logic MATCH_IRQ_OUT,
  output logic [7:0] PORT2_DIR_OUT
);

  //////////////////////////////////////////////////////////////////////////
  // decoding helpers

  function automatic logic wr_hit(input logic we, input logic [15:0] a,
                                  input logic [15:0] reg_addr);
    wr_hit = we && (a == reg_addr);
  endfunction : wr_hit

  function automatic logic cap_hit(input logic [1:0] sel, input logic rise,
                                   input logic fall);
    case (sel)
      CAP_RISE: cap_hit = rise;
      CAP_FALL: cap_hit = fall;
      CAP_BOTH: cap_hit = rise | fall;
      default: cap_hit = 1'b0;
    endcase
  endfunction : cap_hit

  //////////////////////////////////////////////////////////////////////////
  // state

  tmc_s tmc_q, tmc_d;
  logic [7:0] dir_q, dir_d;
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] cmp_q, cmp_d;
  logic [15:0] cap_q, cap_d;
  logic [15:0] buf_q, buf_d;
  logic hold_q, hold_d;
  logic [4:0] pre_q, pre_d;
  logic [7:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic oe_q, oe_d;
  logic [2:0] sync_q, sync_d;
  logic pin_q, pin_d;

  logic tick;
  logic match;
  logic wrap;
  logic rise;
  logic fall;
  logic cap_now;

  //////////////////////////////////////////////////////////////////////////
  // count clock, match, capture edge

  always_comb begin
    pre_d = (pre_q == PRESCALE_LAST) ? 5'h0 : pre_q + 5'h1;
    // prohibited codes simply stop the count clock
    case (tmc_q.clk_sel)
      CLK_SEL_FULL: tick = 1'b1;
      CLK_SEL_DIV32: tick = (pre_q == PRESCALE_LAST);
      default: tick = 1'b0;
    endcase
    match = tick && (cnt_q == cmp_q);
    wrap = tick && (cnt_q == CNT_ALL_ONES);
    // three-stage synchroniser; stage 0 feeds stage 1 only
    sync_d = {sync_q[1:0], CAPTURE_PIN_IN};
    pin_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : pin_q;
    rise = (sync_q[1] == sync_q[2]) && sync_q[2] && !pin_q;
    fall = (sync_q[1] == sync_q[2]) && !sync_q[2] && pin_q;
    cap_now = cap_hit(tmc_q.cap_edge, rise, fall) &&
              (tmc_q.clk_sel != CLK_SEL_FULL);
  end

  //////////////////////////////////////////////////////////////////////////
  // counter, compare, capture, read buffer

  always_comb begin
    cnt_d = tick ? cnt_q + 16'h0001 : cnt_q;
    cmp_d = cmp_q;
    if (wr_hit(WR_IN, ADDR_IN, ADDR_CMP_LO)) begin
      cmp_d[7:0] = WDATA_IN;
    end
    if (wr_hit(WR_IN, ADDR_IN, ADDR_CMP_HI)) begin
      cmp_d[15:8] = WDATA_IN;
    end
    // same-cycle latch is well inside the two count clock limit
    cap_d = cap_now ? cnt_q : cap_q;
    buf_d = hold_q ? buf_q : cnt_q;
    hold_d = hold_q;
    if (RD_IN && ADDR_IN == ADDR_CNT_LO) begin
      buf_d = cnt_q;
      hold_d = 1'b1;
    end else if (RD_IN && ADDR_IN == ADDR_CNT_HI) begin
      hold_d = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // mode control, direction, output pin, interrupt

  always_comb begin
    tmc_d = tmc_q;
    dir_d = dir_q;
    if (wr_hit(WR_IN, ADDR_IN, ADDR_TMC)) begin
      tmc_d.cap_edge = WDATA_IN[TMC_CAP_HI:TMC_CAP_LO];
      tmc_d.inv_en = WDATA_IN[TMC_INV_EN];
      tmc_d.clk_sel = WDATA_IN[TMC_CLK_HI:TMC_CLK_LO];
      tmc_d.pin_en = WDATA_IN[TMC_PIN_EN];
      if (!WDATA_IN[TMC_OVF]) begin
        tmc_d.ovf = 1'b0;
      end
    end
    // overflow set beats a same-cycle software clear
    if (wrap) begin
      tmc_d.ovf = 1'b1;
    end
    if (match && tmc_q.inv_en) begin
      tmc_d.out_level = !tmc_q.out_level;
    end
    if (wr_hit(WR_IN, ADDR_IN, ADDR_PORT2_DIR)) begin
      dir_d = WDATA_IN;
    end
    irq_d = match;
    // pin driven only with output enabled and direction set to output
    oe_d = tmc_d.pin_en && !dir_d[DIR_OUT_PIN_BIT];
  end

  //////////////////////////////////////////////////////////////////////////
  // read port

  always_comb begin
    rdata_d = RD_UNMAPPED;
    if (RD_IN) begin
      case (ADDR_IN)
        ADDR_PORT2_DIR: rdata_d = dir_q;
        ADDR_TMC: rdata_d = tmc_q;
        ADDR_CNT_LO: rdata_d = cnt_q[7:0];
        ADDR_CNT_HI: rdata_d = hold_q ? buf_q[15:8] : cnt_q[15:8];
        ADDR_CMP_LO: rdata_d = cmp_q[7:0];
        ADDR_CMP_HI: rdata_d = cmp_q[15:8];
        ADDR_CAP_LO: rdata_d = cap_q[7:0];
        ADDR_CAP_HI: rdata_d = cap_q[15:8];
        default: rdata_d = RD_UNMAPPED;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registers

  // count clock and capture pin front end
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      pre_q <= 5'h0;
      // idle level of the pin is low, so no false edge after reset
      sync_q <= 3'h0;
      pin_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      sync_q <= sync_d;
      pin_q <= pin_d;
    end
  end

  // counter, compare, capture and read buffer
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      cnt_q <= RST_CNT;
      cmp_q <= RST_CMP;
      cap_q <= RST_CAP;
      buf_q <= RST_CNT;
      hold_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      cmp_q <= cmp_d;
      cap_q <= cap_d;
      buf_q <= buf_d;
      hold_q <= hold_d;
    end
  end

  // mode control, direction, output pin and interrupt
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      tmc_q <= tmc_s'(RST_TMC);
      dir_q <= RST_PORT2_DIR;
      irq_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      tmc_q <= tmc_d;
      dir_q <= dir_d;
      irq_q <= irq_d;
      oe_q <= oe_d;
    end
  end

  // read port
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      rdata_q <= RD_UNMAPPED;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign RDATA_OUT = rdata_q;
  assign TIMER_PIN_OUT = tmc_q.out_level;
  assign TIMER_PIN_OE_OUT = oe_q;
  assign MATCH_IRQ_OUT = irq_q;
  assign PORT2_DIR_OUT = dir_q;

endmodule : frt_timer

// ---- pkg/frt_pkg.sv ----
// constants, field layout and control struct of the free-running timer
package frt_pkg;

  // register byte addresses
  localparam logic [15:0] ADDR_PORT2_DIR = 16'hff22;
  localparam logic [15:0] ADDR_TMC = 16'hff48;
  localparam logic [15:0] ADDR_CNT_LO = 16'hff10;
  localparam logic [15:0] ADDR_CNT_HI = 16'hff11;
  localparam logic [15:0] ADDR_CMP_LO = 16'hff12;
  localparam logic [15:0] ADDR_CMP_HI = 16'hff13;
  localparam logic [15:0] ADDR_CAP_LO = 16'hff14;
  localparam logic [15:0] ADDR_CAP_HI = 16'hff15;

  // reset values, counter wrap value and unmapped read data
  localparam logic [7:0] RST_PORT2_DIR = 8'hff;
  localparam logic [7:0] RST_TMC = 8'h00;
  localparam logic [15:0] RST_CMP = 16'hffff;
  localparam logic [15:0] RST_CNT = 16'h0000;
  localparam logic [15:0] RST_CAP = 16'h0000;
  localparam logic [15:0] CNT_ALL_ONES = 16'hffff;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // field positions in the mode control byte
  localparam int TMC_OUT_LEVEL = 7;
  localparam int TMC_OVF = 6;
  localparam int TMC_CAP_HI = 5;
  localparam int TMC_CAP_LO = 4;
  localparam int TMC_INV_EN = 3;
  localparam int TMC_CLK_HI = 2;
  localparam int TMC_CLK_LO = 1;
  localparam int TMC_PIN_EN = 0;

  // direction bit of the shared timer output pin
  localparam int DIR_OUT_PIN_BIT = 6;

  // count clock codes and prescaler
  localparam logic [1:0] CLK_SEL_FULL = 2'h0;
  localparam logic [1:0] CLK_SEL_DIV32 = 2'h1;
  localparam int PRESCALE_DIV = 32;
  localparam logic [4:0] PRESCALE_LAST = 5'(PRESCALE_DIV - 1);

  // capture edge codes
  localparam logic [1:0] CAP_OFF = 2'h0;
  localparam logic [1:0] CAP_RISE = 2'h1;
  localparam logic [1:0] CAP_FALL = 2'h2;
  localparam logic [1:0] CAP_BOTH = 2'h3;

  typedef struct packed {
    logic out_level;
    logic ovf;
    logic [1:0] cap_edge;
    logic inv_en;
    logic [1:0] clk_sel;
    logic pin_en;
  } tmc_s;

endpackage : frt_pkg

// ---- test/frt_timer_properties.sv ----
// port-level assertions of the free-running timer
`timescale 1ns/10ps
module frt_timer_properties
  import frt_pkg::*;
(
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [15:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [7:0] RDATA_OUT,
  input wire logic TIMER_PIN_OUT,
  input wire logic TIMER_PIN_OE_OUT,
  input wire logic MATCH_IRQ_OUT,
  input wire logic [7:0] PORT2_DIR_OUT
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  ////////////////////////////////////////////////////////////////////////
  a_irq_one_cycle: assert property (MATCH_IRQ_OUT |=> !MATCH_IRQ_OUT)
    else $error("match request too long");
  a_reset_idle: assert property ($rose(RST_N_IN) |->
    PORT2_DIR_OUT == RST_PORT2_DIR && !TIMER_PIN_OE_OUT && !TIMER_PIN_OUT)
    else $error("outputs not idle after reset");
  a_dir_write: assert property (WR_IN && ADDR_IN == ADDR_PORT2_DIR
    |=> PORT2_DIR_OUT == $past(WDATA_IN)) else $error("direction write");
  a_dir_hold: assert property (!(WR_IN && ADDR_IN == ADDR_PORT2_DIR)
    |=> $stable(PORT2_DIR_OUT)) else $error("direction moved");
  a_dir_read: assert property (RD_IN && ADDR_IN == ADDR_PORT2_DIR
    |=> RDATA_OUT == $past(PORT2_DIR_OUT)) else $error("direction read");
  a_pin_at_match: assert property ($changed(TIMER_PIN_OUT)
    |-> MATCH_IRQ_OUT) else $error("pin moved without match");
  a_oe_pin_en: assert property (WR_IN && ADDR_IN == ADDR_TMC |=>
    TIMER_PIN_OE_OUT == ($past(WDATA_IN[TMC_PIN_EN])
    && !PORT2_DIR_OUT[DIR_OUT_PIN_BIT])) else $error("pin enable");
  a_rd_idle: assert property (!$past(RD_IN) |-> RDATA_OUT == 8'h00)
    else $error("read data outside read cycle");
  c_match_on_pin: cover property (MATCH_IRQ_OUT && TIMER_PIN_OE_OUT);
  c_pin_rise: cover property ($rose(TIMER_PIN_OUT));
  c_oe_rise: cover property ($rose(TIMER_PIN_OE_OUT));
endmodule : frt_timer_properties

// ---- test/frt_pin_model.sv ----
// far-side pins: capture source and the shared output pin
`timescale 1ns/10ps
module frt_pin_model (
  input wire logic clk_in,
  input wire logic edge_req_in,
  input wire logic timer_pin_in,
  input wire logic oe_in,
  output logic capture_pin_out,
  output logic pin_level_out
);
  // port latch held at 0, so the pin idles low once handed back
  assign pin_level_out = oe_in ? timer_pin_in : 1'b0;
  // pin moves on the falling edge, unrelated to the sampling edge
  initial capture_pin_out = 1'b0;
  always @(negedge clk_in) capture_pin_out <= edge_req_in;
endmodule : frt_pin_model

// ---- test/testbench.sv ----
// self-checking bench of the free-running timer
`timescale 1ns/10ps
module testbench
  import frt_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, cap_req = 1'b0;
  logic [15:0] addr = 16'h0000, v, c;
  logic [7:0] wdata = 8'h00, rdata, dir, d;
  logic pin, oe, irq, cap_pin, pin_lvl;
  int n_mismatch = 0, checks = 0, k = 0;
  typedef struct packed {logic [15:0] a; logic [7:0] w; logic [7:0] e;} row_s;
  // last rows leave full clock and compare fffd for the match test
  row_s rows [9] = '{'{16'hff22, 8'h00, 8'h00}, '{16'hff48, 8'h32, 8'h32},
    '{16'hff48, 8'h22, 8'h22}, '{16'hff48, 8'h04, 8'h04},
    '{16'hff48, 8'hc0, 8'h00}, '{16'hff14, 8'h55, 8'h00},
    '{16'hff30, 8'h5a, 8'h00}, '{16'hff12, 8'hfd, 8'hfd},
    '{16'hff13, 8'hff, 8'hff}};
  frt_timer dut (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
    .CAPTURE_PIN_IN(cap_pin), .TIMER_PIN_OUT(pin),
    .TIMER_PIN_OE_OUT(oe), .MATCH_IRQ_OUT(irq), .PORT2_DIR_OUT(dir));
  frt_pin_model far (.clk_in(clk), .edge_req_in(cap_req),
    .timer_pin_in(pin), .oe_in(oe), .capture_pin_out(cap_pin),
    .pin_level_out(pin_lvl));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr8(input logic [15:0] a, input logic [7:0] w);
    addr <= a;
    wdata <= w;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr8
  // read data are taken at the edge that closes their one valid cycle
  task automatic rd8(input logic [15:0] a, output logic [7:0] q);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    q = rdata;
  endtask : rd8
  task automatic rd16(input logic [15:0] a, output logic [15:0] q);
    logic [7:0] l, h;
    rd8(a, l);
    rd8(a + 16'h0001, h);
    q = {h, l};
  endtask : rd16
  task automatic final_report;
    $display("counts: %0d checks, %0d mismatches", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////
  initial forever #5 clk = ~clk;
  initial begin
    // about 66k cycles expected; keep the whole run under 90k cycles
    #900_000;
    n_mismatch++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(16'(dir), 16'(RST_PORT2_DIR));
    chk(16'({pin, oe, irq, pin_lvl}), 16'h0000);
    rd8(ADDR_TMC, d);
    chk(16'(d), 16'(RST_TMC));
    rd16(ADDR_CMP_LO, v);
    chk(v, RST_CMP);
    $display("reset tests done");
    for (int i = 0; i < 9; i++) begin
      wr8(rows[i].a, rows[i].w);
      rd8(rows[i].a, d);
      chk(16'(d), 16'(rows[i].e));
    end
    $display("register tests done");
    // compare fffd with inversion: lo read sees ffff, hi read after wrap
    wr8(ADDR_TMC, 8'h09);
    while (irq !== 1'b1 && k < 70000) begin
      @(posedge clk);
      k++;
    end
    rd16(ADDR_CNT_LO, v);
    chk(v, 16'hffff);
    chk(16'({pin, oe, pin_lvl}), 16'h0007);
    rd8(ADDR_TMC, d);
    chk(16'(d), 16'h00c9);
    wr8(ADDR_TMC, 8'h49);
    rd8(ADDR_TMC, d);
    chk(16'(d), 16'h00c9);
    wr8(ADDR_TMC, 8'h09);
    rd8(ADDR_TMC, d);
    chk(16'(d), 16'h0089);
    rd16(ADDR_CNT_LO, v);
    chk(16'(v[15:8]), 16'h0000);
    $display("match test done");
    wr8(ADDR_TMC, 8'h12);
    cap_req <= 1'b1;
    repeat (8) @(posedge clk);
    rd16(ADDR_CAP_LO, c);
    rd16(ADDR_CNT_LO, v);
    chk(16'(v - c <= 16'h0001), 16'h0001);
    wr8(ADDR_TMC, 8'h10);
    cap_req <= 1'b0;
    repeat (8) @(posedge clk);
    cap_req <= 1'b1;
    repeat (8) @(posedge clk);
    rd16(ADDR_CAP_LO, v);
    chk(v, c);
    $display("capture tests done");
    // mid-run reset must bring direction, mode control, compare and count high byte back to their reset values
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(16'(dir), 16'(RST_PORT2_DIR));
    chk(16'({pin, oe, irq}), 16'h0000);
    rd8(ADDR_TMC, d);
    chk(16'(d), 16'(RST_TMC));
    rd16(ADDR_CMP_LO, v);
    chk(v, RST_CMP);
    rd16(ADDR_CNT_LO, v);
    chk(16'(v[15:8]), 16'h0000);
    $display("second reset test done");
    final_report();
  end
endmodule : testbench
bind frt_timer frt_timer_properties chk_i (.CORE_CLK_IN(CORE_CLK_IN),
  .RST_N_IN(RST_N_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
  .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
  .TIMER_PIN_OUT(TIMER_PIN_OUT), .TIMER_PIN_OE_OUT(TIMER_PIN_OE_OUT),
  .MATCH_IRQ_OUT(MATCH_IRQ_OUT), .PORT2_DIR_OUT(PORT2_DIR_OUT));
